//--- src/acs_sequencer.sv
// Command sequencer: command SRAM, fetch/execute engine, counter and checksum
`timescale 1ns/1ps
`default_nettype none

module acs_sequencer
  import acs_pkg::*;
(
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // Control bits from the host register file
  input  wire logic                        sequencer_run_enable,
  input  wire logic                        sequencer_pause,
  input  wire logic [ACS_PWD_W-1:0]        post_write_delay_count,
  input  wire logic [1:0]                  seq_select,
  input  wire acs_seq_info_s [3:0]         seq_info,
  input  wire logic                        count_write,
  // Start triggers
  input  wire logic                        wake_trigger,
  input  wire logic                        spi_start,
  input  wire logic                        gpio_start_pin,
  // Command memory load port
  input  wire logic                        mem_wr,
  input  wire logic [ACS_ADDR_W-1:0]       mem_waddr,
  input  wire logic [31:0]                 mem_wdata,
  // Register write issue
  output acs_mmr_wr_s                      mmr_write,
  // Status
  output logic                             busy,
  output logic                             seq_done,
  output logic [1:0]                       active_seq,
  output logic [ACS_CNT_W-1:0]             executed_command_count,
  output logic [7:0]                       command_checksum,
  output logic [ACS_TMR_W-1:0]             timeout_count,
  output logic                             timeout_done
);

  // ----------------------------------------------------------------
  // Reset release and pin synchroniser
  // ----------------------------------------------------------------
  logic rst_s1_ff;
  logic rst_sync_n;
  logic gpio_s1_ff;
  logic gpio_s2_ff;

  // Reset asserts at once, releases two edges later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_ff  <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1_ff  <= 1'b1;
      rst_sync_n <= rst_s1_ff;
    end
  end

  // Pin is asynchronous: two flops before anything looks at it
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      gpio_s1_ff <= 1'b0;
      gpio_s2_ff <= 1'b0;
    end else begin
      gpio_s1_ff <= gpio_start_pin;
      gpio_s2_ff <= gpio_s1_ff;
    end
  end

  // ----------------------------------------------------------------
  // Engine state
  // ----------------------------------------------------------------
  typedef struct packed {
    acs_state_e            st;
    logic [1:0]            seq;
    logic [ACS_ADDR_W-1:0] rd_addr;
    logic [ACS_ADDR_W-1:0] remain;
    logic [ACS_TMR_W-1:0]  dly;
    logic [ACS_TMR_W-1:0]  tmo;
    logic                  tmo_done;
    logic                  done;
    logic [ACS_CNT_W-1:0]  cnt;
    logic [7:0]            crc;
    acs_mmr_wr_s           wr;
    logic                  gpio_prev;
    logic                  busy;
  } acs_state_s;

  acs_state_s s_ff;
  acs_state_s nxt_s;

  logic exec_go;
  logic trigger;
  logic is_write;
  logic is_tmo;

  // ----------------------------------------------------------------
  // Command memory
  // ----------------------------------------------------------------
  logic [31:0] cmd_mem [ACS_MEM_WORDS];
  logic [31:0] rdata_ff;

  // Host fills it; the engine only reads, it never writes back
  // The read runs every cycle, so a paused engine keeps seeing the same word
  always_ff @(posedge clk) begin
    if (mem_wr) begin
      cmd_mem[mem_waddr] <= mem_wdata;
    end
    rdata_ff <= cmd_mem[s_ff.rd_addr];
  end

  assign exec_go  = (s_ff.st == ACS_EXEC) && sequencer_run_enable && !sequencer_pause;
  assign trigger  = wake_trigger | spi_start | (gpio_s2_ff ^ s_ff.gpio_prev);
  assign is_write = rdata_ff[ACS_CMD_WRITE_BIT];
  assign is_tmo   = rdata_ff[ACS_CMD_TMO_BIT];

  // Next-state logic for the whole engine
  always_comb begin
    nxt_s           = s_ff;
    nxt_s.wr.valid  = 1'b0;
    nxt_s.done      = 1'b0;
    nxt_s.tmo_done  = 1'b0;
    nxt_s.gpio_prev = gpio_s2_ff;
    // Clear first, so a command executed in the same cycle still counts
    if (count_write) begin
      nxt_s.cnt = '0;
      nxt_s.crc = ACS_CRC_SEED;
    end
    if (!sequencer_run_enable) begin
      // Abort: back to idle and drop the timeout counter
      nxt_s.st  = ACS_IDLE;
      nxt_s.tmo = '0;
      nxt_s.dly = '0;
    end else if (!sequencer_pause) begin
      // Timeout counts on its own, one tick per clock
      if (s_ff.tmo != '0) begin
        nxt_s.tmo = s_ff.tmo - 1'b1;
        if (s_ff.tmo == ACS_TMR_W'(1)) begin
          nxt_s.tmo_done = 1'b1;
        end
      end
      case (s_ff.st)
        ACS_IDLE: begin
          if (trigger) begin
            nxt_s.seq     = seq_select;
            nxt_s.rd_addr = seq_info[seq_select].start;
            nxt_s.remain  = seq_info[seq_select].count;
            if (seq_info[seq_select].count == '0) begin
              nxt_s.done = 1'b1;
            end else begin
              nxt_s.st = ACS_FETCH;
            end
          end
        end
        ACS_FETCH: begin
          // Memory read is registered: word is valid next cycle
          nxt_s.st = ACS_EXEC;
        end
        ACS_EXEC: begin
          nxt_s.cnt     = nxt_s.cnt + 1'b1;
          nxt_s.crc     = acs_crc8_fold(nxt_s.crc, rdata_ff);
          nxt_s.rd_addr = s_ff.rd_addr + 1'b1;
          nxt_s.remain  = s_ff.remain - 1'b1;
          if (is_write) begin
            nxt_s.wr.valid = 1'b1;
            nxt_s.wr.addr  = rdata_ff[ACS_WR_ADDR_MSB:ACS_WR_ADDR_LSB];
            nxt_s.wr.data  = rdata_ff[ACS_WR_DATA_MSB:0];
            nxt_s.dly      = {{(ACS_TMR_W-ACS_PWD_W){1'b0}}, post_write_delay_count};
          end else if (is_tmo) begin
            nxt_s.tmo = rdata_ff[ACS_TMR_W-1:0];
            nxt_s.dly = '0;
          end else begin
            nxt_s.dly = rdata_ff[ACS_TMR_W-1:0];
          end
          if (nxt_s.dly != '0) begin
            nxt_s.st = ACS_DELAY;
          end else if (s_ff.remain == ACS_ADDR_W'(1)) begin
            nxt_s.st   = ACS_IDLE;
            nxt_s.done = 1'b1;
          end else begin
            nxt_s.st = ACS_FETCH;
          end
        end
        ACS_DELAY: begin
          nxt_s.dly = s_ff.dly - 1'b1;
          if (s_ff.dly == ACS_TMR_W'(1)) begin
            if (s_ff.remain == '0) begin
              nxt_s.st   = ACS_IDLE;
              nxt_s.done = 1'b1;
            end else begin
              nxt_s.st = ACS_FETCH;
            end
          end
        end
        default: begin
          nxt_s.st = ACS_IDLE;
        end
      endcase
    end
    // Busy gets a flop of its own so the output needs no decode
    nxt_s.busy = (nxt_s.st != ACS_IDLE);
  end

  // Single state register; reset values are constants only
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_ff     <= '0;
      s_ff.st  <= ACS_IDLE;
      s_ff.crc <= ACS_CRC_SEED;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  // Status stays readable while paused, so software can inspect it
  assign mmr_write              = s_ff.wr;
  assign busy                   = s_ff.busy;
  assign seq_done               = s_ff.done;
  assign active_seq             = s_ff.seq;
  assign executed_command_count = s_ff.cnt;
  assign command_checksum       = s_ff.crc;
  assign timeout_count          = s_ff.tmo;
  assign timeout_done           = s_ff.tmo_done;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_sync_n);

  mmr_from_write_a: assert property (mmr_write.valid |-> $past(exec_go) && $past(is_write))
    else $error("register write issued without a write command");

  cnt_step_a: assert property (exec_go && !count_write |=>
      executed_command_count == $past(executed_command_count) + 1'b1)
    else $error("command counter did not step by one");

  cnt_clear_a: assert property (count_write && !exec_go |=>
      executed_command_count == '0 && command_checksum == ACS_CRC_SEED)
    else $error("counter write did not clear counter and seed checksum");

  crc_fold_a: assert property (exec_go && !count_write |=>
      command_checksum == acs_crc8_fold($past(command_checksum), $past(rdata_ff)))
    else $error("checksum not folded in one cycle");

  pause_hold_a: assert property (sequencer_pause && sequencer_run_enable |=>
      $stable(s_ff.st) && $stable(s_ff.rd_addr) && $stable(timeout_count))
    else $error("engine moved while paused");

  stop_clear_a: assert property (!sequencer_run_enable |=>
      !busy && timeout_count == '0)
    else $error("run enable low did not stop and clear");

  post_delay_a: assert property (exec_go && is_write && post_write_delay_count != '0 |=>
      s_ff.st == ACS_DELAY && s_ff.dly == ACS_TMR_W'($past(post_write_delay_count)))
    else $error("post-write delay not loaded");

  wait_nodelay_a: assert property (exec_go && !is_write &&
      (is_tmo || rdata_ff[ACS_TMR_W-1:0] == '0) |=> s_ff.st != ACS_DELAY)
    else $error("post-write delay applied after a timer command");

  addr_order_a: assert property (exec_go |=> s_ff.rd_addr == $past(s_ff.rd_addr) + 1'b1)
    else $error("fetch address did not advance by one");

  // ----------------------------------------------------------------
  // Start, selection and execution checks
  // ----------------------------------------------------------------
  // A taken trigger starts the chosen sequence on the next edge
  start_taken_a: assert property (s_ff.st == ACS_IDLE && trigger &&
      sequencer_run_enable && !sequencer_pause && seq_info[seq_select].count != '0 |=>
      busy && active_seq == $past(seq_select))
    else $error("trigger did not start the selected sequence");

  // While a sequence runs no trigger may switch to another one
  single_seq_a: assert property (busy |=> active_seq == $past(active_seq))
    else $error("active sequence changed while busy");

  // A fetch hands over to execution one edge later unless paused or stopped
  fetch_exec_a: assert property (s_ff.st == ACS_FETCH && sequencer_run_enable &&
      !sequencer_pause |=> s_ff.st == ACS_EXEC)
    else $error("fetch did not lead to execution");

  // Address and data fields go out exactly as the command carried them
  mmr_fields_a: assert property (exec_go && is_write |=>
      mmr_write.addr == $past(rdata_ff[ACS_WR_ADDR_MSB:ACS_WR_ADDR_LSB]) &&
      mmr_write.data == $past(rdata_ff[ACS_WR_DATA_MSB:0]))
    else $error("register write fields differ from the command");

  // Timer commands never reach the register side
  timer_silent_a: assert property (exec_go && !is_write |=> !mmr_write.valid)
    else $error("register write issued for a timer command");

  // Counter and checksum move only on execution or a host clear
  crc_hold_a: assert property (!exec_go && !count_write |=> $stable(command_checksum))
    else $error("checksum changed without a command or clear");

  cnt_hold_a: assert property (!exec_go && !count_write |=>
      $stable(executed_command_count))
    else $error("counter changed without a command or clear");

  // A clear in the same cycle as a command leaves that command counted
  clear_exec_a: assert property (count_write && exec_go |=>
      executed_command_count == ACS_CNT_W'(1) &&
      command_checksum == acs_crc8_fold(ACS_CRC_SEED, $past(rdata_ff)))
    else $error("clear and execute in one cycle mishandled");

  // Delay counts one clock per cycle unless paused
  dly_tick_a: assert property (s_ff.st == ACS_DELAY && sequencer_run_enable &&
      !sequencer_pause |=> s_ff.dly == $past(s_ff.dly) - 1'b1)
    else $error("delay counter did not count down by one");

  // A timeout command loads its count; the engine carries on at once
  tmo_load_a: assert property (exec_go && !is_write && is_tmo |=>
      timeout_count == $past(rdata_ff[ACS_TMR_W-1:0]) && s_ff.st != ACS_DELAY)
    else $error("timeout command did not load its counter");

  // A running timeout drops by one each cycle it is not reloaded
  tmo_tick_a: assert property (sequencer_run_enable && !sequencer_pause &&
      timeout_count != '0 && !(exec_go && !is_write && is_tmo) |=>
      timeout_count == $past(timeout_count) - 1'b1)
    else $error("timeout counter did not count down by one");

  // The done pulse marks the step from one to zero
  tmo_done_a: assert property (timeout_done |-> $past(timeout_count) == ACS_TMR_W'(1))
    else $error("timeout done without the count ending");

  // End of sequence leaves the engine idle with nothing left to run
  done_idle_a: assert property (seq_done |-> !busy && s_ff.remain == '0)
    else $error("sequence ended with commands left");

  // ----------------------------------------------------------------
  // Cover points
  // ----------------------------------------------------------------
  cov_write_c:   cover property (mmr_write.valid ##1 mmr_write.valid [*1] or
                                 mmr_write.valid ##2 mmr_write.valid);
  cov_wait_c:    cover property (exec_go && !is_write && !is_tmo ##1 s_ff.st == ACS_DELAY);
  cov_done_c:    cover property (busy ##1 seq_done);
  cov_timeout_c: cover property (timeout_done);
  cov_pause_c:   cover property (busy && sequencer_pause ##1 busy);

endmodule : acs_sequencer

`default_nettype wire

//--- src/acs_pkg.sv
// Constants, types and the checksum fold shared by the command sequencer
// ----------------------------------------------------------------------
// Summary of operation
// - Four stored sequences, one runs, software picks
// - Each command writes a register or waits
// - Commands run in strict address order
// - No register read-back, writes and delays only
// - Run enable high starts, low stops
// - Idle post-write delay cycles after each write
// - No post-write delay after wait or timeout
// - Back-to-back writes then one wait allowed
// - Pause freezes sequencing and timers until cleared
// - Host reads still served while paused
// - Executed-command counter increments per executed command
// - Any counter write clears the counter
// - Running CRC-8, polynomial x8+x2+x+1, over commands
// - Whole command word folded in one cycle
// - Counter write reloads checksum with seed one
// - Checksum is read-only to the host
// - Start from wake timer, SPI, or pin toggle
// - Commands held in six kilobyte on-chip SRAM
// - MSB one: write, address bits 8:2, data 23:0
// - Wait and timeout count system clock periods
// - Timeout runs on, cleared when enable written zero
// ----------------------------------------------------------------------
`default_nettype none

package acs_pkg;

  // Command memory: 6 kB of 32-bit words
  localparam int          ACS_MEM_WORDS  = 1536;
  localparam int          ACS_ADDR_W     = 11;
  localparam int          ACS_CNT_W      = 16;
  localparam int          ACS_PWD_W      = 8;
  localparam int          ACS_TMR_W      = 30;

  // Command word layout
  localparam int          ACS_CMD_WRITE_BIT = 31;
  localparam int          ACS_CMD_TMO_BIT   = 30;
  localparam int          ACS_WR_ADDR_MSB   = 30;
  localparam int          ACS_WR_ADDR_LSB   = 24;
  localparam int          ACS_WR_DATA_MSB   = 23;

  // Checksum
  localparam logic [7:0]  ACS_CRC_POLY   = 8'h07;
  localparam logic [7:0]  ACS_CRC_SEED   = 8'h01;

  typedef enum logic [1:0] {
    ACS_IDLE  = 2'b00,
    ACS_FETCH = 2'b01,
    ACS_EXEC  = 2'b10,
    ACS_DELAY = 2'b11
  } acs_state_e;

  typedef struct packed {
    logic [ACS_ADDR_W-1:0] count;
    logic [ACS_ADDR_W-1:0] start;
  } acs_seq_info_s;

  typedef struct packed {
    logic        valid;
    logic [6:0]  addr;
    logic [23:0] data;
  } acs_mmr_wr_s;

  // Fold one command word into the checksum, MSB first
  function automatic logic [7:0] acs_crc8_fold(input logic [7:0]  crc,
                                               input logic [31:0] word);
    logic [7:0] c;
    logic       fb;
    c = crc;
    for (int i = 31; i >= 0; i--) begin
      fb = c[7] ^ word[i];
      c  = {c[6:0], 1'b0};
      if (fb) begin
        c = c ^ ACS_CRC_POLY;
      end
    end
    return c;
  endfunction : acs_crc8_fold

endpackage : acs_pkg

`default_nettype wire

//--- tb/acs_mmr_model.sv
// Register target model: logs every register write the sequencer issues
`timescale 1ns/1ps
`default_nettype none

module acs_mmr_model
  import acs_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Write issue from the sequencer
  input  wire acs_mmr_wr_s mmr_write
);
  logic [30:0] log_w [256];
  int          log_t [256];
  int          n;
  int          cyc;

  // Write-only target: it offers nothing to read back, so each written word and its cycle are all we keep
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      n   <= 0;
      cyc <= 0;
    end else begin
      cyc <= cyc + 1;
      if (mmr_write.valid === 1'b1) begin
        log_w[n[7:0]] <= {mmr_write.addr, mmr_write.data};
        log_t[n[7:0]] <= cyc;
        n             <= n + 1;
      end
    end
  end
endmodule : acs_mmr_model

`default_nettype wire

//--- tb/acs_sequencer_tb_top.sv
// Self-checking bench for the command sequencer
`timescale 1ns/1ps
`default_nettype none

module acs_sequencer_tb_top
  import acs_pkg::*;
;
  logic                  clk = 1'b0;
  logic                  rst_n, run_en, pause, cnt_wr, wake, spi, gpio, mem_wr;
  logic [ACS_PWD_W-1:0]  pwd;
  logic [1:0]            sel, act;
  acs_seq_info_s [3:0]   info;
  logic [ACS_ADDR_W-1:0] waddr;
  logic [31:0]           wdata;
  acs_mmr_wr_s           mmr;
  logic                  busy, done, tdone;
  logic [ACS_CNT_W-1:0]  cnt, exp_cnt;
  logic [7:0]            crc, exp_crc;
  logic [ACS_TMR_W-1:0]  tmo;
  logic [31:0]           seed = 32'h0000bbce;
  int                    num_errors = 0;
  int                    n_tests = 0;

  always #25 clk = ~clk;

  acs_sequencer u_dut (
    .clk(clk), .rst_n(rst_n), .sequencer_run_enable(run_en), .sequencer_pause(pause),
    .post_write_delay_count(pwd), .seq_select(sel), .seq_info(info), .count_write(cnt_wr),
    .wake_trigger(wake), .spi_start(spi), .gpio_start_pin(gpio), .mem_wr(mem_wr),
    .mem_waddr(waddr), .mem_wdata(wdata), .mmr_write(mmr), .busy(busy), .seq_done(done),
    .active_seq(act), .executed_command_count(cnt), .command_checksum(crc),
    .timeout_count(tmo), .timeout_done(tdone)
  );

  acs_mmr_model u_mdl (.clk(clk), .rst_n(rst_n), .mmr_write(mmr));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Bit-serial reference, kept apart from the design's own fold
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [31:0] w);
    logic [7:0] r;
    r = c;
    for (int i = 31; i >= 0; i--) begin
      r = (r[7] ^ w[i]) ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
    end
    return r;
  endfunction : crc_step

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  task automatic final_report();
    if (num_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask : tick

  task automatic load(input int a, input logic [31:0] w);
    mem_wr = 1'b1;
    waddr  = ACS_ADDR_W'(a);
    wdata  = w;
    tick(1);
    mem_wr = 1'b0;
    // Idle edge so a following load never re-raises the strobe in one step
    tick(1);
  endtask : load

  // Kind 0 host command, 1 wake timer, 2 pin toggle
  task automatic trig(input int kind);
    spi  = (kind == 0);
    wake = (kind == 1);
    gpio ^= (kind == 2);
    tick(1);
    spi  = 1'b0;
    wake = 1'b0;
  endtask : trig

  // Random sequence: expected write order, spacing, count and checksum
  task automatic run_seq(input logic [1:0] s, input int kind, input int n, input bit pz);
    logic [31:0]          w, r;
    logic [30:0]          ew[$];
    int                   et[$];
    int                   t, m0, k;
    logic [ACS_CNT_W-1:0] snap;
    t = 0;
    for (k = 0; k < n; k++) begin
      r = rnd();
      w = (k == 0 || !r[1]) ? {1'b1, r[8:2], r[31:8]} : {1'b0, r[0], 27'h0, r[4:2]};
      load(s * 64 + k, w);
      exp_crc = crc_step(exp_crc, w);
      if (w[31]) begin
        ew.push_back(w[30:0]);
        et.push_back(t + 1);
      end
      t += 2 + (w[31] ? int'(pwd) : (w[30] ? 0 : int'(w[2:0])));
    end
    exp_cnt += ACS_CNT_W'(n);
    info[s] = '{count: ACS_ADDR_W'(n), start: ACS_ADDR_W'(s * 64)};
    sel = s;
    m0 = u_mdl.n;
    trig(kind);
    // Pause mid-run: no writes and a frozen counter while it is held
    for (k = 1; k < 400 && done !== 1'b1; k++) begin
      pause = pz && k >= 6 && k < 14;
      if (k == 9) snap = cnt;
      if (pz && k > 8 && k < 14) begin
        check(mmr.valid, 1'b0);
        check(cnt, snap);
      end
      tick(1);
    end
    check(done, 1'b1);
    check(busy, 1'b0);
    // A last write lands in the model one edge after done
    tick(1);
    check(act, s);
    check(u_mdl.n - m0, ew.size());
    for (k = 0; k < ew.size(); k++) begin
      check(u_mdl.log_w[m0 + k], ew[k]);
      if (!pz && k > 0) begin
        check(u_mdl.log_t[m0 + k] - u_mdl.log_t[m0 + k - 1], et[k] - et[k - 1]);
      end
    end
    check(cnt, exp_cnt);
    check(crc, exp_crc);
  endtask : run_seq

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst_n, run_en, pause, cnt_wr, wake, spi, gpio, mem_wr} = '0;
    pwd     = '0;
    sel     = '0;
    info    = '0;
    waddr   = '0;
    wdata   = '0;
    exp_cnt = '0;
    exp_crc = ACS_CRC_SEED;
    tick(8);
    rst_n = 1'b1;
    tick(3);
    check(crc, 8'h01);
    check(cnt, '0);
    run_en = 1'b1;
    // First run with zero delay gives back-to-back writes
    for (int r = 0; r < 6; r++) begin
      pwd = (r == 0) ? '0 : ACS_PWD_W'(rnd() % 5);
      run_seq(2'(r), r % 3, (r == 4) ? 12 : 4 + int'(rnd() % 8), r == 4);
    end
    cnt_wr = 1'b1;
    tick(1);
    cnt_wr = 1'b0;
    tick(1);
    check(cnt, '0);
    check(crc, ACS_CRC_SEED);
    // Triggers with the engine disabled or paused are dropped
    run_en = 1'b0;
    trig(0);
    tick(4);
    check(busy, 1'b0);
    run_en = 1'b1;
    pause  = 1'b1;
    trig(0);
    tick(4);
    check(busy, 1'b0);
    pause = 1'b0;
    // Abort while a timeout runs: the counter must be cleared
    load(192, {2'b01, 30'h3e8});
    load(193, {2'b00, 30'hc8});
    info[3] = '{count: 11'h2, start: 11'hc0};
    sel = 2'h3;
    trig(1);
    tick(9);
    check(busy, 1'b1);
    check(tmo > 30'h3d4 && tmo < 30'h3e8, 1'b1);
    run_en = 1'b0;
    tick(2);
    check(busy, 1'b0);
    check(tmo, '0);
    check(cnt, 16'h2);
    check(crc, crc_step(crc_step(ACS_CRC_SEED, {2'b01, 30'h3e8}), {2'b00, 30'hc8}));
    // Short timeout left to run out: done pulses as the count reaches zero
    run_en = 1'b1;
    load(194, {2'b01, 30'h5});
    info[3] = '{count: 11'h1, start: 11'hc2};
    trig(0);
    tick(6);
    check(tdone, 1'b0);
    check(tmo, 30'h1);
    tick(1);
    check(tdone, 1'b1);
    check(tmo, '0);
    check(cnt, 16'h3);
    final_report();
  end

  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #3_000_000;
    num_errors++;
    final_report();
  end
endmodule : acs_sequencer_tb_top

`default_nettype wire
